//--- fac_regs.svh
// fac_regs.svh: constants of the flash array read controller
// assumes: included by bare name, after the controller package
`ifndef FAC_REGS_SVH
`define FAC_REGS_SVH

// ----------------------------------------------------------------------
// address spaces behind the controller
// ----------------------------------------------------------------------
`define FAC_SPACE_MAIN    2'h0
`define FAC_SPACE_TEST    2'h1
`define FAC_SPACE_SHADOW  2'h2

// ----------------------------------------------------------------------
// field positions of the byte address
// ----------------------------------------------------------------------
`define FAC_DW_BIT        3
`define FAC_LINE_LSB      4
`define FAC_LINE_MSB      19
`define FAC_UNIT_LSB      14

// ----------------------------------------------------------------------
// sector limits, in 16 KB units, one past the last unit of each sector
// ----------------------------------------------------------------------
`define FAC_SEC0_END      6'h01
`define FAC_SEC1_END      6'h04
`define FAC_SEC2_END      6'h07
`define FAC_SEC3_END      6'h08
`define FAC_SEC4_END      6'h0C
`define FAC_SEC5_END      6'h10
`define FAC_SEC6_END      6'h18
`define FAC_SEC7_END      6'h20
`define FAC_SEC8_END      6'h30

// ----------------------------------------------------------------------
// wait states of an array access by ws_sel code, buffer count, round-robin reset
// ----------------------------------------------------------------------
`define FAC_WS_60MHZ      2'h1
`define FAC_WS_80MHZ      2'h2
`define FAC_WS_120MHZ     2'h3
`define FAC_BUF_COUNT     4
`define FAC_RR_RESET      2'h0

`endif

//--- fac_pkg.sv
// fac_pkg.sv: types and shared functions of the flash array controller
// assumes: compiled before every other file of the block
package fac_pkg;

	typedef enum logic [1:0] {
		FAC_IDLE,
		FAC_WAIT
	} fac_state_type;

	typedef logic [17:0] fac_tag_type;

	// check byte of one 64-bit word: hamming syndrome plus overall parity
	function automatic logic [7:0] fac_ecc_check(input logic [63:0] d);
		logic [6:0] s;
		int         k;
		s = 7'h00;
		k = 0;
		for (int pos = 3; pos < 72; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (d[k])
					s = s ^ 7'(pos);
				k++;
			end
		end
		return {(^d) ^ (^s), s};
	endfunction

endpackage

//--- fac_ecc.sv
// fac_ecc.sv: secded check and correction of one stored 72-bit word
// assumes: word is {check byte, data} as written by fac_ctrl
`timescale 1ns/1ps

module fac_ecc (
	input  wire logic [71:0] word,
	output logic      [63:0] data,
	output logic             single,
	output logic             double
);
	import fac_pkg::*;

	// ------------------------------------------------------------------
	// syndrome
	// ------------------------------------------------------------------
	wire logic [63:0] raw    = word[63:0];
	wire logic [7:0]  stored = word[71:64];
	wire logic [7:0]  calc   = fac_ecc_check(raw);
	wire logic [6:0]  syn    = calc[6:0] ^ stored[6:0];
	wire logic        par    = (^raw) ^ (^stored);

	// odd parity means one flipped bit; even parity with a syndrome means two
	assign single = par;
	assign double = !par && (syn != 7'h00);

	// ------------------------------------------------------------------
	// correction: flip the data bit the syndrome points at
	// ------------------------------------------------------------------
	always_comb begin
		int k;
		k = 0;
		data = raw;
		for (int pos = 3; pos < 72; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (par && syn == 7'(pos))
					data[k] = !raw[k];
				k++;
			end
		end
	end

endmodule // fac_ecc

//--- fac_ctrl.sv
// fac_ctrl.sv: flash array controller between system bus and array
// assumes: one master holds bus_req and its fields until ready or error;
// the array presents arr_rdata ws cycles after arr_rd_en rises.
//
// Function
// - bus slave port carries 64-bit read and write data.
// - array reads fetch one whole 128-bit line at a time.
// - four prefetch buffers each hold one line and serve hits.
// - a read that hits a buffer answers with no wait state.
// - a miss answers after three wait states at top clock rate.
// - wait states selectable: three to 120, two to 80, one to 60 MHz.
// - each 64-bit word stored with 8 check bits, checked on every array read.
// - single-bit errors corrected, double-bit errors detected only.
// - writes go to the array 64 bits wide; reads stay 128 bits.
// - main array decoded into ten sectors of the given sizes in order.
// - separate 16 KB test sector and 16 KB shadow block exist.
`timescale 1ns/1ps
`include "fac_regs.svh"

module fac_ctrl (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          bus_req,
	input  wire logic          bus_write,
	input  wire logic [1:0]    bus_space,
	input  wire logic [19:0]   bus_addr,
	input  wire logic [63:0]   bus_wdata,
	output logic               bus_ready,
	output logic               bus_err,
	output logic      [63:0]   bus_rdata,
	input  wire logic [1:0]    ws_sel,
	input  wire logic          erase_req,
	input  wire logic [1:0]    erase_space,
	input  wire logic [3:0]    erase_sector,
	output logic               arr_rd_en,
	output logic               arr_wr_en,
	output logic      [1:0]    arr_space,
	output logic      [15:0]   arr_line,
	output logic               arr_dword,
	output logic      [3:0]    arr_sector,
	output logic      [71:0]   arr_wdata,
	input  wire logic [143:0]  arr_rdata,
	output logic               ecc_fixed,
	output logic               ecc_fatal
);
	import fac_pkg::*;

	// ------------------------------------------------------------------
	// decode functions
	// ------------------------------------------------------------------
	function automatic logic [3:0] fac_sector(input logic [15:0] line);
		logic [5:0] u;
		u = line[15:10];
		if (u < `FAC_SEC0_END)      return 4'h0;
		else if (u < `FAC_SEC1_END) return 4'h1;
		else if (u < `FAC_SEC2_END) return 4'h2;
		else if (u < `FAC_SEC3_END) return 4'h3;
		else if (u < `FAC_SEC4_END) return 4'h4;
		else if (u < `FAC_SEC5_END) return 4'h5;
		else if (u < `FAC_SEC6_END) return 4'h6;
		else if (u < `FAC_SEC7_END) return 4'h7;
		else if (u < `FAC_SEC8_END) return 4'h8;
		else                        return 4'h9;
	endfunction

	// an unknown code falls back to the slowest setting, safe at any clock
	function automatic logic [1:0] fac_ws(input logic [1:0] sel);
		return (sel == 2'h0) ? `FAC_WS_120MHZ : sel;
	endfunction

	function automatic logic [1:0] fac_idx(input logic [3:0] v);
		return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	fac_state_type st_r;
	fac_state_type st_nxt;
	logic [1:0]    cnt_r;
	logic          wr_r;
	logic          fill_ok_r;
	logic [1:0]    rr_r;
	logic [3:0]    vld_r;
	logic [3:0]    vld_nxt;
	fac_tag_type   tag_r [`FAC_BUF_COUNT];
	logic [127:0]  line_r [`FAC_BUF_COUNT];

	// ------------------------------------------------------------------
	// request decode
	// ------------------------------------------------------------------
	wire logic [15:0] req_line = bus_addr[`FAC_LINE_MSB:`FAC_LINE_LSB];
	wire fac_tag_type req_tag  = {bus_space, req_line};
	wire logic [1:0]  ws_eff   = fac_ws(ws_sel);
	wire logic        take     = bus_req && st_r == FAC_IDLE
	                             && !bus_ready && !bus_err;
	// test and shadow are 16 KB each: any higher unit is unmapped
	wire logic        bad_addr = bus_space == 2'h3
	                             || (bus_space != `FAC_SPACE_MAIN
	                             && bus_addr[19:`FAC_UNIT_LSB] != 6'h00);
	wire logic [3:0]  hit_vec;
	wire logic [3:0]  cur_vec;
	wire logic [3:0]  ers_vec;
	wire fac_tag_type cur_tag  = {arr_space, arr_line};

	for (genvar i = 0; i < `FAC_BUF_COUNT; i++) begin : g_match
		assign hit_vec[i] = vld_r[i] && tag_r[i] == req_tag;
		assign cur_vec[i] = vld_r[i] && tag_r[i] == cur_tag;
		assign ers_vec[i] = vld_r[i] && tag_r[i][17:16] == erase_space
		                    && (erase_space != `FAC_SPACE_MAIN
		                    || fac_sector(tag_r[i][15:0]) == erase_sector);
	end

	wire logic        hit      = |hit_vec;
	wire logic [1:0]  hit_idx  = fac_idx(hit_vec);
	wire logic [63:0] hit_data = bus_addr[`FAC_DW_BIT]
	                             ? line_r[hit_idx][127:64]
	                             : line_r[hit_idx][63:0];
	wire logic        go_hit   = take && !bad_addr && !bus_write && hit;
	wire logic        go_arr   = take && !bad_addr && !(hit && !bus_write);
	wire logic        done     = st_r == FAC_WAIT && cnt_r == 2'h1;

	// in-flight line erased: its fill would bring back stale contents
	wire logic        ers_cur  = erase_req && arr_space == erase_space
	                             && (erase_space != `FAC_SPACE_MAIN
	                             || arr_sector == erase_sector);

	// ------------------------------------------------------------------
	// array read path and check
	// ------------------------------------------------------------------
	logic [63:0] d0;
	logic [63:0] d1;
	logic        s0;
	logic        s1;
	logic        e0;
	logic        e1;

	fac_ecc u_ecc_lo (
		.word   (arr_rdata[71:0]),
		.data   (d0),
		.single (s0),
		.double (e0)
	);

	fac_ecc u_ecc_hi (
		.word   (arr_rdata[143:72]),
		.data   (d1),
		.single (s1),
		.double (e1)
	);

	wire logic        rd_done  = done && !wr_r;
	wire logic        rd_fatal = rd_done && (e0 || e1);
	wire logic        rd_fix   = rd_done && !(e0 || e1) && (s0 || s1);
	wire logic        fill     = rd_done && !(e0 || e1) && fill_ok_r
	                             && !ers_cur;
	wire logic [63:0] arr_word = arr_dword ? d1 : d0;

	// ------------------------------------------------------------------
	// buffer validity
	// ------------------------------------------------------------------
	always_comb begin
		vld_nxt = vld_r;
		if (take && bus_write)
			vld_nxt = vld_nxt & ~hit_vec;
		if (erase_req)
			vld_nxt = vld_nxt & ~ers_vec;
		if (fill)
			vld_nxt[rr_r] = 1'b1;
	end

	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			FAC_IDLE: begin
				if (go_arr)
					st_nxt = FAC_WAIT;
			end
			FAC_WAIT: begin
				if (done)
					st_nxt = FAC_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// sequencing registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_r      <= FAC_IDLE;
			cnt_r     <= 2'h0;
			wr_r      <= 1'b0;
			fill_ok_r <= 1'b0;
			rr_r      <= `FAC_RR_RESET;
			vld_r     <= 4'h0;
		end else begin
			st_r  <= st_nxt;
			vld_r <= vld_nxt;
			if (go_arr) begin
				cnt_r     <= ws_eff;
				wr_r      <= bus_write;
				fill_ok_r <= 1'b1;
			end else if (st_r == FAC_WAIT) begin
				cnt_r <= cnt_r - 2'h1;
				if (ers_cur)
					fill_ok_r <= 1'b0;
			end
			if (fill)
				rr_r <= rr_r + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (fill) begin
			tag_r[rr_r]  <= cur_tag;
			line_r[rr_r] <= {d1, d0};
		end
	end

	// ------------------------------------------------------------------
	// bus answer, all outputs registered
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			bus_ready <= 1'b0;
			bus_err   <= 1'b0;
			bus_rdata <= 64'h0000000000000000;
			ecc_fixed <= 1'b0;
			ecc_fatal <= 1'b0;
		end else begin
			bus_ready <= go_hit || (done && !rd_fatal);
			bus_err   <= (take && bad_addr) || rd_fatal;
			ecc_fixed <= rd_fix;
			ecc_fatal <= rd_fatal;
			if (go_hit)
				bus_rdata <= hit_data;
			else if (rd_done && !rd_fatal)
				bus_rdata <= arr_word;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			arr_rd_en  <= 1'b0;
			arr_wr_en  <= 1'b0;
			arr_space  <= `FAC_SPACE_MAIN;
			arr_line   <= 16'h0000;
			arr_dword  <= 1'b0;
			arr_sector <= 4'h0;
			arr_wdata  <= 72'h000000000000000000;
		end else begin
			if (go_arr) begin
				arr_rd_en  <= !bus_write;
				arr_wr_en  <= bus_write;
				arr_space  <= bus_space;
				arr_line   <= req_line;
				arr_dword  <= bus_addr[`FAC_DW_BIT];
				arr_sector <= fac_sector(req_line);
				arr_wdata  <= {fac_ecc_check(bus_wdata), bus_wdata};
			end else if (done) begin
				arr_rd_en <= 1'b0;
				arr_wr_en <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	wire logic miss_rd = take && !bad_addr && !bus_write && !hit;

	a_hit_no_wait: assert property (
		go_hit |=> bus_ready && !bus_err && bus_rdata == $past(hit_data))
		else $error("hit not answered in the next cycle");
	a_miss_three_ws: assert property (
		miss_rd && ws_eff == 2'h3 |=> !bus_ready [*3] ##1 (bus_ready || bus_err))
		else $error("miss at three wait states answered at wrong cycle");
	a_miss_two_ws: assert property (
		miss_rd && ws_eff == 2'h2 |=> !bus_ready [*2] ##1 (bus_ready || bus_err))
		else $error("miss at two wait states answered at wrong cycle");
	a_miss_one_ws: assert property (
		miss_rd && ws_eff == 2'h1 |=> !bus_ready ##1 (bus_ready || bus_err))
		else $error("miss at one wait state answered at wrong cycle");
	a_rd_wr_excl: assert property (
		arr_rd_en |-> !arr_wr_en && ($stable(arr_line) || $rose(arr_rd_en)))
		else $error("array read overlaps a write or line moved");
	a_wr_check_byte: assert property (
		arr_wr_en |-> arr_wdata[71:64] == fac_ecc_check(arr_wdata[63:0]))
		else $error("written check byte does not match data");
	a_fatal_is_err: assert property (
		rd_fatal |=> bus_err && ecc_fatal && !bus_ready)
		else $error("uncorrectable read not ended by error");
	a_fix_returns: assert property (
		rd_fix |=> bus_ready && ecc_fixed && bus_rdata == $past(arr_word))
		else $error("corrected read did not return corrected data");
	a_bad_addr_err: assert property (
		take && bad_addr |=> bus_err && !bus_ready && !arr_rd_en)
		else $error("unmapped space not refused");
	a_wr_invalid: assert property (
		arr_wr_en |-> cur_vec == 4'h0)
		else $error("buffer still holds a line being written");
	a_one_answer: assert property (
		bus_ready |-> !bus_err ##1 !bus_ready)
		else $error("answer held or doubled");

	c_hit_read:  cover property (go_hit ##1 bus_ready);
	c_miss_read: cover property (miss_rd ##[1:4] bus_ready);
	c_write:     cover property (arr_wr_en ##[1:3] bus_ready);
	c_corrected: cover property (rd_fix ##1 ecc_fixed);

endmodule // fac_ctrl

//--- fac_array_model.sv
// fac_array_model.sv: behavioural flash array behind fac_ctrl
// assumes: one clock; bench drives flip to inject stored-bit errors
`timescale 1ns/1ps

module fac_array_model (
	input  wire logic          clk,
	input  wire logic          arr_rd_en,
	input  wire logic          arr_wr_en,
	input  wire logic [1:0]    arr_space,
	input  wire logic [15:0]   arr_line,
	input  wire logic          arr_dword,
	input  wire logic [71:0]   arr_wdata,
	input  wire logic [143:0]  flip,
	output logic      [143:0]  arr_rdata
);
	bit [143:0] mem [bit [17:0]];
	bit [143:0] t;
	int         wr_cnt;

	initial begin
		arr_rdata = '0;
		wr_cnt = 0;
	end

	// ------------------------------------------------------------
	// storage: 72-bit words written, 144-bit lines read
	// ------------------------------------------------------------
	always @(posedge clk) begin
		if (arr_wr_en) begin
			t = mem.exists({arr_space, arr_line}) ?
				mem[{arr_space, arr_line}] : '0;
			if (arr_dword)
				t[143:72] = arr_wdata;
			else
				t[71:0] = arr_wdata;
			mem[{arr_space, arr_line}] = t;
			wr_cnt++;
		end
	end

	// released data lines invert so a stale value never matches
	always @(arr_rd_en, arr_space, arr_line, flip, wr_cnt) begin
		if (arr_rd_en && mem.exists({arr_space, arr_line}))
			arr_rdata = mem[{arr_space, arr_line}] ^ flip;
		else if (arr_rd_en)
			arr_rdata = flip;
		else
			arr_rdata = ~arr_rdata;
	end
endmodule // fac_array_model

//--- flash_array_read_controller_bench.sv
// flash_array_read_controller_bench.sv: self-checking bench of fac_ctrl
// assumes: fac_array_model stands on the array port
`timescale 1ns/1ps

module flash_array_read_controller_bench;
	logic          clk;
	logic          nrst;
	logic          bus_req;
	logic          bus_write;
	logic [1:0]    bus_space;
	logic [19:0]   bus_addr;
	logic [63:0]   bus_wdata;
	logic          bus_ready;
	logic          bus_err;
	logic [63:0]   bus_rdata;
	logic [1:0]    ws_sel;
	logic          erase_req;
	logic [1:0]    erase_space;
	logic [3:0]    erase_sector;
	logic          arr_rd_en;
	logic          arr_wr_en;
	logic [1:0]    arr_space;
	logic [15:0]   arr_line;
	logic          arr_dword;
	logic [3:0]    arr_sector;
	logic [71:0]   arr_wdata;
	logic [143:0]  arr_rdata;
	logic [143:0]  flip;
	logic          ecc_fixed;
	logic          ecc_fatal;
	logic          fx;
	logic          ft;
	int            miscompares = 0;
	int            total_checks = 0;
	localparam logic [63:0] da = 64'h0123_4567_89AB_CDEF;
	localparam logic [63:0] db = 64'hFEDC_BA98_7654_3210;

	fac_ctrl i_fac_ctrl (.clk(clk), .nrst(nrst), .bus_req(bus_req),
		.bus_write(bus_write), .bus_space(bus_space), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_ready(bus_ready), .bus_err(bus_err),
		.bus_rdata(bus_rdata), .ws_sel(ws_sel), .erase_req(erase_req),
		.erase_space(erase_space), .erase_sector(erase_sector),
		.arr_rd_en(arr_rd_en), .arr_wr_en(arr_wr_en),
		.arr_space(arr_space), .arr_line(arr_line),
		.arr_dword(arr_dword), .arr_sector(arr_sector),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata),
		.ecc_fixed(ecc_fixed), .ecc_fatal(ecc_fatal));

	fac_array_model i_fac_array_model (.clk(clk), .arr_rd_en(arr_rd_en),
		.arr_wr_en(arr_wr_en), .arr_space(arr_space),
		.arr_line(arr_line), .arr_dword(arr_dword),
		.arr_wdata(arr_wdata), .flip(flip), .arr_rdata(arr_rdata));

	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [71:0] got, input logic [71:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// reference check byte: hamming over positions 1..71, data in
	// non-power-of-two positions ascending, top bit overall parity
	function automatic logic [7:0] ref_ecc(input logic [63:0] d);
		logic [6:0] s;
		int         k;
		s = 7'h00;
		k = 0;
		for (int p = 1; p < 72; p++) begin
			if ((p & (p - 1)) != 0) begin
				s = s ^ (d[k] ? 7'(p) : 7'h00);
				k++;
			end
		end
		return {^{d, s}, s};
	endfunction

	// one bus transfer; latency counts edges from take to answer
	task automatic xfer(input logic wr, input logic [1:0] sp,
		input logic [19:0] ad, input logic [63:0] wd,
		input int el, input logic ee, input logic [63:0] ed);
		int n;
		@(posedge clk);
		bus_req <= 1'h1;
		bus_write <= wr;
		bus_space <= sp;
		bus_addr <= ad;
		bus_wdata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((bus_ready | bus_err) !== 1'h1 && n < 9);
		fx = ecc_fixed;
		ft = ecc_fatal;
		check(72'(n), 72'(el));
		check(72'(bus_err), 72'(ee));
		if (!wr && !ee)
			check(72'(bus_rdata), 72'(ed));
		@(posedge clk);
		bus_req <= 1'h0;
	endtask

	task automatic set_ws(input logic [1:0] w);
		@(posedge clk);
		ws_sel <= w;
	endtask

	task automatic erase(input logic [1:0] sp, input logic [3:0] s);
		@(posedge clk);
		erase_space <= sp;
		erase_sector <= s;
		erase_req <= 1'h1;
		@(posedge clk);
		erase_req <= 1'h0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_rw;
		set_ws(2'h3);
		xfer(1'h1, 2'h0, 20'h00100, da, 4, 1'h0, 64'h0);
		check(arr_wdata, {ref_ecc(da), da});
		check(72'(arr_line), 72'h10);
		xfer(1'h1, 2'h0, 20'h00108, db, 4, 1'h0, 64'h0);
		xfer(1'h0, 2'h0, 20'h00100, 64'h0, 4, 1'h0, da);
		xfer(1'h0, 2'h0, 20'h00108, 64'h0, 1, 1'h0, db);
		$display("test rw done");
	endtask

	task automatic t_ws;
		logic [19:0] a;
		for (int w = 0; w < 4; w++) begin
			a = 20'h00200 + 20'(w * 16);
			set_ws(2'(w));
			xfer(1'h0, 2'h0, a, 64'h0, w == 0 ? 4 : w + 1, 1'h0, 64'h0);
			xfer(1'h0, 2'h0, a, 64'h0, 1, 1'h0, 64'h0);
		end
		$display("test ws done");
	endtask

	// four fills cover every buffer; the fifth evicts the oldest
	task automatic t_buf;
		set_ws(2'h1);
		for (int i = 0; i < 8; i++)
			xfer(1'h0, 2'h0, 20'h00400 + 20'((i % 4) * 16), 64'h0,
				i < 4 ? 2 : 1, 1'h0, 64'h0);
		xfer(1'h0, 2'h0, 20'h00440, 64'h0, 2, 1'h0, 64'h0);
		for (int i = 1; i < 4; i++)
			xfer(1'h0, 2'h0, 20'h00400 + 20'(i * 16), 64'h0, 1, 1'h0,
				64'h0);
		xfer(1'h0, 2'h0, 20'h00400, 64'h0, 2, 1'h0, 64'h0);
		$display("test buf done");
	endtask

	task automatic t_ecc;
		set_ws(2'h2);
		xfer(1'h1, 2'h0, 20'h00600, da, 3, 1'h0, 64'h0);
		xfer(1'h1, 2'h0, 20'h00608, db, 3, 1'h0, 64'h0);
		xfer(1'h1, 2'h0, 20'h00610, da, 3, 1'h0, 64'h0);
		flip <= (144'h1 << 100) | 144'h20;
		xfer(1'h0, 2'h0, 20'h00600, 64'h0, 3, 1'h0, da);
		check(72'(fx), 72'h1);
		xfer(1'h0, 2'h0, 20'h00608, 64'h0, 1, 1'h0, db);
		flip <= 144'h3;
		xfer(1'h0, 2'h0, 20'h00610, 64'h0, 3, 1'h1, 64'h0);
		check(72'(ft), 72'h1);
		flip <= 144'h0;
		xfer(1'h0, 2'h0, 20'h00610, 64'h0, 3, 1'h0, da);
		check(72'(fx), 72'h0);
		$display("test ecc done");
	endtask

	task automatic t_space;
		set_ws(2'h1);
		for (int s = 0; s < 3; s++)
			xfer(1'h1, 2'(s), 20'h0, da ^ 64'(s), 2, 1'h0, 64'h0);
		for (int s = 0; s < 3; s++)
			xfer(1'h0, 2'(s), 20'h0, 64'h0, 2, 1'h0, da ^ 64'(s));
		xfer(1'h0, 2'h1, 20'h03FF0, 64'h0, 2, 1'h0, 64'h0);
		xfer(1'h1, 2'h1, 20'h04000, da, 1, 1'h1, 64'h0);
		xfer(1'h0, 2'h2, 20'h7FFF0, 64'h0, 1, 1'h1, 64'h0);
		xfer(1'h0, 2'h3, 20'h0, 64'h0, 1, 1'h1, 64'h0);
		$display("test space done");
	endtask

	// first and last line of each sector, sizes in 16 KB units
	task automatic t_sec;
		int sz[10] = '{1, 3, 3, 1, 4, 4, 8, 8, 16, 16};
		int u;
		u = 0;
		for (int s = 0; s < 10; s++) begin
			xfer(1'h1, 2'h0, 20'(u << 14), da, 2, 1'h0, 64'h0);
			check(72'(arr_sector), 72'(s));
			u += sz[s];
			xfer(1'h1, 2'h0, 20'((u << 14) - 16), da, 2, 1'h0, 64'h0);
			check(72'(arr_sector), 72'(s));
		end
		$display("test sector done");
	endtask

	task automatic t_inv;
		xfer(1'h1, 2'h0, 20'h00800, da, 2, 1'h0, 64'h0);
		xfer(1'h0, 2'h0, 20'h00800, 64'h0, 2, 1'h0, da);
		xfer(1'h1, 2'h0, 20'h00800, db, 2, 1'h0, 64'h0);
		xfer(1'h0, 2'h0, 20'h00800, 64'h0, 2, 1'h0, db);
		erase(2'h0, 4'h5);
		xfer(1'h0, 2'h0, 20'h00800, 64'h0, 1, 1'h0, db);
		erase(2'h0, 4'h0);
		xfer(1'h0, 2'h0, 20'h00800, 64'h0, 2, 1'h0, db);
		// erase of a whole test sector drops its buffered lines
		xfer(1'h0, 2'h1, 20'h0, 64'h0, 2, 1'h0, da ^ 64'h1);
		xfer(1'h0, 2'h1, 20'h0, 64'h0, 1, 1'h0, da ^ 64'h1);
		erase(2'h1, 4'h0);
		xfer(1'h0, 2'h1, 20'h0, 64'h0, 2, 1'h0, da ^ 64'h1);
		$display("test invalidate done");
	endtask

	initial begin
		nrst = 1'h0;
		bus_req = 1'h0;
		bus_write = 1'h0;
		bus_space = 2'h0;
		bus_addr = 20'h0;
		bus_wdata = 64'h0;
		ws_sel = 2'h3;
		erase_req = 1'h0;
		erase_space = 2'h0;
		erase_sector = 4'h0;
		flip = 144'h0;
		repeat (10) @(posedge clk);
		nrst <= 1'h1;
		t_rw();
		t_ws();
		t_buf();
		t_ecc();
		t_space();
		t_sec();
		t_inv();
		finish_test();
	end

	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule // flash_array_read_controller_bench
